//--- rtl/scrs_top.sv
/*
 * system control / reset status block: low-power entry gating, software
 * reset trigger, reset cause capture, reset vector select, power-on-only
 * scratch registers, id halves and regulator standby control.
 * assumes: por_i is the asynchronous power-on reset (rst_i); sys_rst_i is
 * the chip-wide system reset level from the reset controller, held for at
 * least one clock; reset request inputs are synchronous to mclk_i.
 */
// Operation
// [RULE_01] software writes zero to all reserved control/status/power bits
// [RULE_02] debug clock gated by tap enable unless always-on bit set
// [RULE_03] writing soft reset bit resets device; bit reads zero
// [RULE_04] halt field: low bit blocks stop entry, high bit locks field
// [RULE_05] idle field: low bit blocks wait entry, high bit locks field
// [RULE_06] reset cause register read-only, updated on every system reset; code updates only on a reset edge with a cause input set, or on pin reset
// [RULE_07] cause cleared async by power-on, then updated by precedence
// [RULE_08] newest reset cause clears all earlier cause flags
// [RULE_09] simultaneous causes: power-on, pin, refloss, timeout, software
// [RULE_10] power-on flag resets to one; pin reset replaces it
// [RULE_11] software cause flag set after software-triggered reset
// [RULE_12] timeout and refloss flags mark watchdog-caused resets
// [RULE_13] watchdog flag set at code start selects watchdog vector
// [RULE_14] pin cause flag set after external pin reset
// [RULE_15] four scratch registers cleared only by power-on reset
// [RULE_16] two read-only id halves ignore writes
// [RULE_17] regulator field: low bit standby, high bit locks field
// [RULE_18] software selects standby only at low bus frequency
// [RULE_19] locked fields ignore writes; any system reset unlocks
// [RULE_20] read-only and reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none

module scrs_top #(
  parameter logic [15:0] ID_HI = scrs_pkg::ID_HI_DEF,
  parameter logic [15:0] ID_LO = scrs_pkg::ID_LO_DEF,
  parameter int unsigned N_SCR = 4
) (
  // clock and power-on reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // system reset level and reset requests
  input wire logic sys_rst_i,
  input wire logic pin_rst_i,
  input wire logic wdog_refloss_i,
  input wire logic wdog_timeout_i,
  // core interface
  input wire logic tap_en_i,
  input wire logic stop_req_i,
  input wire logic wait_req_i,
  output logic dbg_clk_en_o,
  output logic stop_ok_o,
  output logic wait_ok_o,
  output logic wdog_vector_o,
  output logic soft_rst_req_o,
  // regulator
  output logic regulator_standby_sel_o,
  // register port
  input wire scrs_pkg::scrs_req_t req_i,
  output logic [15:0] rdata_o
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (N_SCR != 4) begin : g_bad_scr
    $error("scratch count must be 4");
  end

  logic wr_ctrl;
  logic wr_pwr;
  logic [15:0] wd;
  scrs_pkg::scrs_lockf_t halt_q;
  scrs_pkg::scrs_lockf_t idle_q;
  scrs_pkg::scrs_lockf_t stby_q;
  logic dbg_always_q;
  scrs_pkg::scrs_cause_t cause_q;
  scrs_pkg::scrs_cause_t cause_d;
  logic [15:0] scr_q [N_SCR];
  logic sys_rst_prev_q;

  assign wd = req_i.wdata;
  assign wr_ctrl = req_i.wr && (req_i.addr == scrs_pkg::OFF_CTRL);
  assign wr_pwr = req_i.wr && (req_i.addr == scrs_pkg::OFF_PWR);

  // ---------------------------------------------------------------
  // control register: lockable fields, cleared by any system reset
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      halt_q <= scrs_pkg::FIELD_RST;
      idle_q <= scrs_pkg::FIELD_RST;
      dbg_always_q <= 1'b0;
    end else if (sys_rst_i) begin
      halt_q <= scrs_pkg::FIELD_RST; // see [RULE_19]
      idle_q <= scrs_pkg::FIELD_RST; // see [RULE_19]
      dbg_always_q <= 1'b0;
    end else if (wr_ctrl) begin
      dbg_always_q <= wd[scrs_pkg::CTRL_DBGCLK];
      if (!halt_q.lock) begin
        halt_q <= wd[scrs_pkg::CTRL_HALT_LO +: 2]; // see [RULE_04]
      end
      if (!idle_q.lock) begin
        idle_q <= wd[scrs_pkg::CTRL_IDLE_LO +: 2]; // see [RULE_05]
      end
    end
  end

  // ---------------------------------------------------------------
  // regulator standby field
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stby_q <= scrs_pkg::FIELD_RST;
    end else if (sys_rst_i) begin
      stby_q <= scrs_pkg::FIELD_RST; // see [RULE_19]
    end else if (wr_pwr && !stby_q.lock) begin
      stby_q <= wd[scrs_pkg::PWR_STBY_LO +: 2]; // see [RULE_17]
    end
  end

  // ---------------------------------------------------------------
  // core-facing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dbg_clk_en_o <= 1'b0;
      stop_ok_o <= 1'b0;
      wait_ok_o <= 1'b0;
      regulator_standby_sel_o <= 1'b0;
      soft_rst_req_o <= 1'b0;
    end else begin
      dbg_clk_en_o <= dbg_always_q || tap_en_i; // see [RULE_02]
      stop_ok_o <= stop_req_i && !halt_q.sel; // see [RULE_04]
      wait_ok_o <= wait_req_i && !idle_q.sel; // see [RULE_05]
      regulator_standby_sel_o <= stby_q.sel; // see [RULE_17]
      // pulse while not already in reset
      soft_rst_req_o <= wr_ctrl && wd[scrs_pkg::CTRL_SOFT_RESET_TRIGGER]
                        && !sys_rst_i; // see [RULE_03]
    end
  end

  // ---------------------------------------------------------------
  // reset cause: latched at the leading edge of a system reset with a cause input set, and when pin reset asserts
  // ---------------------------------------------------------------
  always_comb begin
    cause_d = scrs_pkg::CAUSE_NONE;
    if (pin_rst_i) begin // see [RULE_09]
      cause_d.ext = 1'b1; // see [RULE_14]
    end else if (wdog_refloss_i) begin
      cause_d.lor = 1'b1; // see [RULE_12]
    end else if (wdog_timeout_i) begin
      cause_d.tor = 1'b1; // see [RULE_12]
    end else if (soft_rst_req_o) begin
      cause_d.soft_reset_cause = 1'b1; // see [RULE_11]
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_q <= scrs_pkg::CAUSE_RST; // see [RULE_07]
      sys_rst_prev_q <= 1'b0;
    end else begin
      sys_rst_prev_q <= sys_rst_i;
      // pin held or asserted later replaces power-on; whole vector
      // replaced so earlier flags clear
      if (pin_rst_i && !cause_q.ext) begin
        cause_q <= cause_d; // see [RULE_10]
      end else if (sys_rst_i && !sys_rst_prev_q
                   && cause_d != scrs_pkg::CAUSE_NONE) begin
        cause_q <= cause_d; // see [RULE_06] see [RULE_08]
      end
    end
  end

  // ---------------------------------------------------------------
  // reset vector select, sampled while code starts
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_vector_o <= 1'b0;
    end else begin
      wdog_vector_o <= cause_q.tor || cause_q.lor; // see [RULE_13]
    end
  end

  // ---------------------------------------------------------------
  // scratch registers, power-on reset only
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N_SCR; i++) begin : g_scr
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        scr_q[i] <= scrs_pkg::SCR_RST; // see [RULE_15]
      end else if (req_i.wr
                   && req_i.addr == scrs_pkg::OFF_SCR0 + 5'(i)) begin
        scr_q[i] <= wd;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port: data stand in the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (req_i.rd) begin
      unique case (req_i.addr)
        scrs_pkg::OFF_CTRL: begin
          rdata_o <= {10'h000, dbg_always_q, 1'b0,
                      halt_q, idle_q}; // see [RULE_03] see [RULE_20]
        end
        scrs_pkg::OFF_RSTAT: begin
          rdata_o <= {9'h000, cause_q, 2'h0}; // see [RULE_20]
        end
        scrs_pkg::OFF_SCR0: begin
          rdata_o <= scr_q[0];
        end
        scrs_pkg::OFF_SCR1: begin
          rdata_o <= scr_q[1];
        end
        scrs_pkg::OFF_SCR2: begin
          rdata_o <= scr_q[2];
        end
        scrs_pkg::OFF_SCR3: begin
          rdata_o <= scr_q[3];
        end
        scrs_pkg::OFF_IDHI: begin
          rdata_o <= ID_HI; // see [RULE_16]
        end
        scrs_pkg::OFF_IDLO: begin
          rdata_o <= ID_LO; // see [RULE_16]
        end
        scrs_pkg::OFF_PWR: begin
          rdata_o <= {14'h0000, stby_q};
        end
        default: begin
          rdata_o <= 16'h0000;
        end
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb_chk @(posedge mclk_i);
  endclocking

  default disable iff (rst_i);

  sequence s_halt_locked;
    halt_q.lock && !sys_rst_i;
  endsequence

  sequence s_idle_locked;
    idle_q.lock && !sys_rst_i;
  endsequence

  sequence s_stby_locked;
    stby_q.lock && !sys_rst_i;
  endsequence

  sequence s_rst_rise;
    sys_rst_i && !sys_rst_prev_q;
  endsequence

  sequence s_soft_write;
    wr_ctrl && wd[scrs_pkg::CTRL_SOFT_RESET_TRIGGER] && !sys_rst_i;
  endsequence

  halt_lock_a: assert property ( // see [RULE_04]
    s_halt_locked ##0 wr_ctrl |=> $stable(halt_q))
    else $error("locked halt field changed");

  idle_lock_a: assert property ( // see [RULE_05]
    s_idle_locked ##0 wr_ctrl |=> $stable(idle_q))
    else $error("locked idle field changed");

  stby_lock_a: assert property ( // see [RULE_17]
    s_stby_locked ##0 wr_pwr |=> $stable(stby_q))
    else $error("locked standby field changed");

  unlock_a: assert property ( // see [RULE_19]
    sys_rst_i |=> (!halt_q.lock && !idle_q.lock && !stby_q.lock))
    else $error("system reset did not unlock fields");

  cause_onehot_a: assert property ( // see [RULE_08]
    $onehot(cause_q))
    else $error("not exactly one cause flag set");

  pin_cause_a: assert property ( // see [RULE_09]
    pin_rst_i |=> cause_q.ext)
    else $error("pin reset not recorded");

  refloss_cause_a: assert property ( // see [RULE_12]
    s_rst_rise ##0 (wdog_refloss_i && !pin_rst_i) |=> cause_q.lor)
    else $error("reference loss reset not recorded");

  timeout_cause_a: assert property ( // see [RULE_12]
    s_rst_rise ##0 (wdog_timeout_i && !wdog_refloss_i && !pin_rst_i)
      |=> cause_q.tor)
    else $error("watchdog timeout reset not recorded");

  prec_cause_a: assert property ( // see [RULE_09]
    s_rst_rise ##0 (pin_rst_i && wdog_refloss_i)
      |=> (cause_q.ext && !cause_q.lor))
    else $error("pin reset lost against reference loss");

  soft_cause_a: assert property ( // see [RULE_11]
    s_soft_write ##1 (s_rst_rise ##0 (!pin_rst_i && !wdog_refloss_i
      && !wdog_timeout_i)) |=> cause_q.soft_reset_cause)
    else $error("software reset not recorded");

  soft_pulse_a: assert property ( // see [RULE_03]
    s_soft_write |=> soft_rst_req_o)
    else $error("software reset request missing");

  soft_reset_trigger_read_a: assert property ( // see [RULE_03]
    (req_i.rd && req_i.addr == scrs_pkg::OFF_CTRL)
      |=> !rdata_o[scrs_pkg::CTRL_SOFT_RESET_TRIGGER])
    else $error("soft reset bit read as one");

  rstat_ro_a: assert property ( // see [RULE_06]
    (req_i.wr && req_i.addr == scrs_pkg::OFF_RSTAT && !sys_rst_i
      && !pin_rst_i) |=> $stable(cause_q))
    else $error("reset cause changed by a write");

  dbg_clk_a: assert property ( // see [RULE_02]
    (dbg_always_q || tap_en_i) |=> dbg_clk_en_o)
    else $error("debug clock not enabled");

  stop_gate_a: assert property ( // see [RULE_04]
    (stop_req_i && halt_q.sel) |=> !stop_ok_o)
    else $error("stop entry not blocked");

  wait_gate_a: assert property ( // see [RULE_05]
    (wait_req_i && idle_q.sel) |=> !wait_ok_o)
    else $error("wait entry not blocked");

  stby_out_a: assert property ( // see [RULE_17]
    stby_q.sel |=> regulator_standby_sel_o)
    else $error("regulator standby not selected");

  vector_a: assert property ( // see [RULE_13]
    (cause_q.tor || cause_q.lor) |=> wdog_vector_o)
    else $error("watchdog vector not selected");

  vector_off_a: assert property ( // see [RULE_13]
    !(cause_q.tor || cause_q.lor) |=> !wdog_vector_o)
    else $error("watchdog vector selected without cause");

  id_read_a: assert property ( // see [RULE_16]
    (req_i.rd && req_i.addr == scrs_pkg::OFF_IDHI)
      |=> (rdata_o == ID_HI))
    else $error("id upper half wrong");

  id_lo_read_a: assert property ( // see [RULE_16]
    (req_i.rd && req_i.addr == scrs_pkg::OFF_IDLO)
      |=> (rdata_o == ID_LO))
    else $error("id lower half wrong");

  scr_keep_a: assert property ( // see [RULE_15]
    (sys_rst_i && !req_i.wr) |=> $stable(scr_q[0]))
    else $error("scratch changed by system reset");

  rdata_idle_a: assert property ( // see [RULE_20]
    !req_i.rd |=> (rdata_o == 16'h0000))
    else $error("read data not zero without a read");

endmodule

`default_nettype wire

//--- rtl/scrs_pkg.sv
/*
 * package for the system control / reset status block: register offsets,
 * field positions, reset values, reset cause encoding and bus carriers.
 * assumes a 16-bit register port addressed by word index.
 */
package scrs_pkg;

  localparam int unsigned DW = 16;
  localparam int unsigned AW = 5;

  // ---------------------------------------------------------------
  // register offsets (word index)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_RSTAT = 5'h01;
  localparam logic [4:0] OFF_SCR0 = 5'h02;
  localparam logic [4:0] OFF_SCR1 = 5'h03;
  localparam logic [4:0] OFF_SCR2 = 5'h04;
  localparam logic [4:0] OFF_SCR3 = 5'h05;
  localparam logic [4:0] OFF_IDHI = 5'h06;
  localparam logic [4:0] OFF_IDLO = 5'h07;
  localparam logic [4:0] OFF_PWR = 5'h08;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_DBGCLK = 5;
  localparam int unsigned CTRL_SOFT_RESET_TRIGGER = 4;
  localparam int unsigned CTRL_HALT_LO = 2;
  localparam int unsigned CTRL_IDLE_LO = 0;
  localparam int unsigned PWR_STBY_LO = 0;
  localparam int unsigned RS_SWR = 6;
  localparam int unsigned RS_TOR = 5;
  localparam int unsigned RS_LOR = 4;
  localparam int unsigned RS_EXT = 3;
  localparam int unsigned RS_POR = 2;
  localparam int unsigned CAUSE_LO = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] FIELD_RST = 2'h0;
  localparam logic [15:0] SCR_RST = 16'h0000;
  localparam logic [4:0] CAUSE_RST = 5'h01;
  localparam logic [4:0] CAUSE_NONE = 5'h00;
  // identification halves: arbitrary neutral values
  localparam logic [15:0] ID_HI_DEF = 16'h0a5c;
  localparam logic [15:0] ID_LO_DEF = 16'h3c01;

  // cause vector, bit order matches status bits 6..2
  typedef struct packed {
    logic soft_reset_cause;
    logic tor;
    logic lor;
    logic ext;
    logic por;
  } scrs_cause_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } scrs_req_t;

  // lockable two-bit field: [1] lock, [0] function
  typedef struct packed {
    logic lock;
    logic sel;
  } scrs_lockf_t;

endpackage

//--- verification/scrs_rst_model.sv
/*
 * reset controller model: merges reset requests into the system reset
 * level seen by the block. assumes requests are synchronous to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module scrs_rst_model (
  // clock and power-on reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // reset requests
  input wire logic soft_req_i,
  input wire logic pin_i,
  input wire logic lor_i,
  input wire logic tor_i,
  // system reset level
  output logic sys_rst_o
);
  logic [2:0] hold_q;
  logic any_req;

  assign any_req = soft_req_i | pin_i | lor_i | tor_i;

  // stretch each request for a few clocks
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= 3'h0;
    end else if (any_req) begin
      hold_q <= 3'h4;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end

  // level rises in the cycle of the request itself
  assign sys_rst_o = any_req | (hold_q != 3'h0);
endmodule

`default_nettype wire

//--- verification/system_control_reset_status_tb_top.sv
/*
 * testbench for scrs_top: register tasks, reset sources, core requests.
 * assumes the reset controller model drives sys_rst_i.
 */
`timescale 1ns/1ps
`default_nettype none

module system_control_reset_status_tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin = 1'b0;
  logic lor = 1'b0;
  logic tor = 1'b0;
  logic tap_en = 1'b0;
  logic stop_req = 1'b0;
  logic wait_req = 1'b0;
  logic sys_rst, dbg_clk, stop_ok, wait_ok, wdog_vec, soft_req, stby;
  scrs_pkg::scrs_req_t req = '0;
  logic [15:0] rdata;
  logic [2:0] s;
  logic [15:0] e;
  logic [2:0] src [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h4};
  int err_total = 0;
  int comparisons = 0;

  always #2.5 mclk_i = ~mclk_i;

  scrs_rst_model u_rst (.mclk_i(mclk_i), .rst_i(rst_i),
    .soft_req_i(soft_req), .pin_i(pin), .lor_i(lor), .tor_i(tor),
    .sys_rst_o(sys_rst));

  scrs_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .sys_rst_i(sys_rst),
    .pin_rst_i(pin), .wdog_refloss_i(lor), .wdog_timeout_i(tor),
    .tap_en_i(tap_en), .stop_req_i(stop_req), .wait_req_i(wait_req),
    .dbg_clk_en_o(dbg_clk), .stop_ok_o(stop_ok), .wait_ok_o(wait_ok),
    .wdog_vector_o(wdog_vec), .soft_rst_req_o(soft_req),
    .regulator_standby_sel_o(stby), .req_i(req), .rdata_o(rdata));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic pulse_src(input logic [2:0] v);
    @(posedge mclk_i);
    {pin, lor, tor} <= v;
    repeat (3) @(posedge mclk_i);
    {pin, lor, tor} <= 3'h0;
    cyc(8);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdc(scrs_pkg::OFF_RSTAT, 16'h0004);
    rdc(scrs_pkg::OFF_CTRL, 16'h0000);
    rdc(scrs_pkg::OFF_PWR, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rdc(scrs_pkg::OFF_SCR0 + i[4:0], 16'h0000);
      wr(scrs_pkg::OFF_SCR0 + i[4:0], i[15:0] + 16'ha5c0);
    end
    wr(scrs_pkg::OFF_IDHI, 16'hffff);
    wr(scrs_pkg::OFF_IDLO, 16'h0000);
    wr(scrs_pkg::OFF_RSTAT, 16'h0078);
    wr(5'h1f, 16'hffff);
    rdc(scrs_pkg::OFF_IDHI, scrs_pkg::ID_HI_DEF);
    rdc(scrs_pkg::OFF_IDLO, scrs_pkg::ID_LO_DEF);
    rdc(scrs_pkg::OFF_RSTAT, 16'h0004);
    rdc(5'h1f, 16'h0000);
    $display("test reset_values done");
    wr(scrs_pkg::OFF_CTRL, 16'h0021);
    rdc(scrs_pkg::OFF_CTRL, 16'h0021);
    cyc(2);
    chk({15'h0, dbg_clk}, 16'h0001);
    wr(scrs_pkg::OFF_CTRL, 16'h0000);
    tap_en <= 1'b1;
    cyc(3);
    chk({15'h0, dbg_clk}, 16'h0001);
    @(posedge mclk_i);
    tap_en <= 1'b0;
    cyc(3);
    chk({15'h0, dbg_clk}, 16'h0000);
    @(posedge mclk_i);
    stop_req <= 1'b1;
    wait_req <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(scrs_pkg::OFF_CTRL, {13'h0, k[1], 1'b0, k[0]});
      cyc(2);
      e = {14'h0, ~k[1], ~k[0]};
      chk({14'h0, stop_ok, wait_ok}, e);
    end
    wr(scrs_pkg::OFF_CTRL, 16'h000e);
    wr(scrs_pkg::OFF_CTRL, 16'h0001);
    rdc(scrs_pkg::OFF_CTRL, 16'h000e);
    cyc(2);
    chk({14'h0, stop_ok, wait_ok}, 16'h0001);
    $display("test control_fields done");
    wr(scrs_pkg::OFF_PWR, 16'h0001);
    cyc(2);
    chk({15'h0, stby}, 16'h0001);
    wr(scrs_pkg::OFF_PWR, 16'h0002);
    rdc(scrs_pkg::OFF_PWR, 16'h0002);
    wr(scrs_pkg::OFF_PWR, 16'h0001);
    rdc(scrs_pkg::OFF_PWR, 16'h0002);
    chk({15'h0, stby}, 16'h0000);
    $display("test regulator done");
    for (int k = 0; k < 5; k++) begin
      s = src[k];
      pulse_src(s);
      e = s[2] ? 16'h0008 : (s[1] ? 16'h0010 : 16'h0020);
      rdc(scrs_pkg::OFF_RSTAT, e);
      chk({15'h0, wdog_vec}, {15'h0, ~s[2]});
    end
    $display("test reset_causes done");
    wr(scrs_pkg::OFF_CTRL, 16'h000f);
    wr(scrs_pkg::OFF_PWR, 16'h0003);
    rdc(scrs_pkg::OFF_CTRL, 16'h000f);
    chk({15'h0, stby}, 16'h0001);
    wr(scrs_pkg::OFF_CTRL, 16'h0010);
    #1;
    chk({15'h0, soft_req}, 16'h0001);
    cyc(10);
    rdc(scrs_pkg::OFF_RSTAT, 16'h0040);
    chk({15'h0, wdog_vec}, 16'h0000);
    rdc(scrs_pkg::OFF_CTRL, 16'h0000);
    rdc(scrs_pkg::OFF_PWR, 16'h0000);
    chk({15'h0, stby}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      e = i[15:0] + 16'ha5c0;
      rdc(scrs_pkg::OFF_SCR0 + i[4:0], e);
    end
    $display("test soft_reset done");
    @(posedge mclk_i);
    rst_i <= 1'b1;
    pin <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    pin <= 1'b0;
    cyc(8);
    rdc(scrs_pkg::OFF_RSTAT, 16'h0008);
    rdc(scrs_pkg::OFF_SCR0, 16'h0000);
    $display("test power_on_pin done");
    finish_test();
  end
endmodule

`default_nettype wire
